// ### rtl/adccal_regs.v
`timescale 1ns/1ps
`include "adccal_defs.vh"

module adccal_regs #(
  parameter WIDTH = 24,
  parameter CAL_CYCLES = `ADCCAL_CAL_CYCLES
) (
  input wire clk,
  input wire sys_rst,
  input wire wr_en,
  input wire rd_en,
  input wire [2:0] reg_sel,
  input wire [1:0] byte_sel,
  input wire [7:0] wr_data,
  input wire sample_valid,
  input wire [WIDTH-1:0] sample_raw,
  input wire [WIDTH-1:0] cal_offs_in,
  input wire [WIDTH-1:0] cal_pfs_in,
  input wire [WIDTH-1:0] cal_nfs_in,
  output reg [7:0] rd_data,
  output reg rd_valid,
  output reg conversion_ready_n,
  output reg [WIDTH-1:0] result,
  output reg [2:0] gain_select,
  output reg bipolar,
  output reg calibrating
);
  localparam ST_CAL = 3'b001;
  // waits for the first sample after a calibration or a restart
  localparam ST_SETTLE = 3'b010;
  localparam ST_RUN = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [23:0] ctrl;
  reg [15:0] cal_cnt;
  reg [2:0] cal_mode;
  reg [2:0] load_mask;
  reg rd_pend;
  reg [1:0] rd_pend_byte;
  reg [2:0] rd_pend_sel;
  reg [7:0] rd_direct;
  wire [WIDTH-1:0] coeff_word;
  wire [WIDTH-1:0] offs_word;
  wire ctrl_wr;
  wire ctrl_upper_wr;
  wire coeff_wr;
  wire [2:0] mode_now;
  wire cal_done;
  wire [2:0] coeff_rd_sel;

  function [7:0] pick_byte;
    input [23:0] word;
    input [1:0] lane;
    begin
      case (lane)
        `ADCCAL_BYTE_LO: pick_byte = word[7:0];
        `ADCCAL_BYTE_MID: pick_byte = word[15:8];
        `ADCCAL_BYTE_HI: pick_byte = word[23:16];
        default: pick_byte = 8'h00;
      endcase
    end
  endfunction

  function is_cal_mode;
    input [2:0] mode;
    begin
      is_cal_mode = (mode != `ADCCAL_MODE_CONVERT) && (mode <= `ADCCAL_MODE_SYS_NFS);
    end
  endfunction

  // selects 2 to 4 are the three coefficient words in the little memory
  function is_coeff_sel;
    input [2:0] sel;
    begin
      is_coeff_sel = (sel >= `ADCCAL_SEL_OFFS) && (sel <= `ADCCAL_SEL_NFS);
    end
  endfunction

  // lane code 3 names no byte of a 24-bit word, so such writes are dropped
  function lane_ok;
    input [1:0] lane;
    begin
      lane_ok = lane != 2'h3;
    end
  endfunction

  assign ctrl_wr = wr_en && reg_sel == `ADCCAL_SEL_CTRL && lane_ok(byte_sel);
  // byte 1 or 2 may retune the filter or switch mode, so a held result is stale
  assign ctrl_upper_wr = ctrl_wr && byte_sel != `ADCCAL_BYTE_LO;
  assign coeff_wr = wr_en && is_coeff_sel(reg_sel) && lane_ok(byte_sel);
  // a byte-1 write decides the mode in its own cycle, not the old copy
  assign mode_now = (ctrl_wr && byte_sel == `ADCCAL_BYTE_MID) ?
    wr_data[`ADCCAL_CTRL_MODE_HI-8:`ADCCAL_CTRL_MODE_LO-8] :
    ctrl[`ADCCAL_CTRL_MODE_HI:`ADCCAL_CTRL_MODE_LO];
  assign cal_done = state == ST_CAL && cal_cnt == 16'h0001;
  assign coeff_rd_sel = reg_sel - `ADCCAL_SEL_OFFS;

  // a finished calibration wins over a host byte written in the same cycle
  adccal_coeff_mem #(
    .WIDTH(WIDTH)
  ) u_mem (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(coeff_wr),
    .wr_index(coeff_rd_sel[1:0]),
    .wr_byte(byte_sel),
    .wr_data(wr_data),
    .load_mask(load_mask),
    .load_offs(cal_offs_in),
    .load_pfs(cal_pfs_in),
    .load_nfs(cal_nfs_in),
    .rd_index(is_coeff_sel(reg_sel) ? coeff_rd_sel[1:0] : 2'h3),
    .rd_word(coeff_word),
    .offs_word(offs_word)
  );

  // which coefficients a finished calibration overwrites
  always @* begin
    load_mask = 3'h0;
    if (cal_done) begin
      case (cal_mode)
        `ADCCAL_MODE_SELF_CAL: load_mask = 3'h7;
        `ADCCAL_MODE_SYS_OFFS: load_mask = 3'h1;
        `ADCCAL_MODE_SYS_PFS: load_mask = 3'h2;
        `ADCCAL_MODE_SYS_NFS: load_mask = 3'h4;
        default: load_mask = 3'h0;
      endcase
    end
  end

  always @* begin
    next_state = state;
    case (state)
      ST_CAL: if (cal_done) next_state = ST_SETTLE;
      ST_SETTLE: if (sample_valid && !ctrl[`ADCCAL_CTRL_STANDBY]) next_state = ST_RUN;
      ST_RUN: next_state = ST_RUN;
      default: next_state = ST_CAL;
    endcase
    // a byte-1 or byte-2 control write restarts the sequence from wherever it stood
    if (ctrl_upper_wr) begin
      next_state = is_cal_mode(mode_now) ? ST_CAL : ST_SETTLE;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_CAL;
      ctrl <= `ADCCAL_CTRL_RESET;
      cal_cnt <= 16'h0000;
      cal_mode <= `ADCCAL_MODE_SELF_CAL;
      conversion_ready_n <= 1'b1;
      result <= {WIDTH{1'b0}};
      gain_select <= 3'h0;
      bipolar <= 1'b1;
      calibrating <= 1'b1;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      rd_pend <= 1'b0;
      rd_pend_byte <= 2'h0;
      rd_pend_sel <= 3'h0;
      rd_direct <= 8'h00;
    end else begin
      state <= next_state;
      calibrating <= next_state == ST_CAL;
      if (ctrl_wr) begin
        ctrl[byte_sel*8 +: 8] <= wr_data;
      end
      gain_select <= ctrl[`ADCCAL_CTRL_GAIN_HI:`ADCCAL_CTRL_GAIN_LO];
      bipolar <= ctrl[`ADCCAL_CTRL_BIPOLAR];
      // a restart reloads the count, so repeated writes stretch calibration
      if (ctrl_upper_wr && is_cal_mode(mode_now)) begin
        cal_mode <= mode_now;
        cal_cnt <= CAL_CYCLES[15:0];
      end else if (state == ST_CAL && cal_cnt > 16'h0001) begin
        cal_cnt <= cal_cnt - 16'h0001;
      end else if (state == ST_CAL && cal_cnt == 16'h0000) begin
        // first cycle after reset: arm the self-calibration
        cal_cnt <= CAL_CYCLES[15:0];
      end else if (cal_done) begin
        cal_cnt <= 16'h0000;
      end
      // new result only outside calibration; standby halts the filter path
      // a clearing write beats a sample in the same cycle; that sample is dropped
      if (ctrl_upper_wr || ctrl[`ADCCAL_CTRL_STANDBY]) begin
        conversion_ready_n <= 1'b1;
      end else if (sample_valid && state != ST_CAL) begin
        // the subtraction wraps; codes near the ends are not clamped
        result <= sample_raw - offs_word;
        conversion_ready_n <= 1'b0;
      end else if (rd_en && reg_sel == `ADCCAL_SEL_DATA && byte_sel == `ADCCAL_BYTE_LO) begin
        // reading the last byte completes the data read
        // the default order is descending, so byte 0 is the last lane
        conversion_ready_n <= 1'b1;
      end
      // coefficient reads wait one cycle for the memory's registered word
      rd_pend <= rd_en;
      rd_pend_byte <= byte_sel;
      rd_pend_sel <= reg_sel;
      rd_direct <= (reg_sel == `ADCCAL_SEL_CTRL) ? pick_byte(ctrl, byte_sel) :
        (reg_sel == `ADCCAL_SEL_DATA) ? pick_byte(result, byte_sel) : 8'h00;
      rd_valid <= rd_pend;
      if (rd_pend) begin
        rd_data <= (rd_pend_sel >= `ADCCAL_SEL_OFFS) ?
          pick_byte(coeff_word, rd_pend_byte) : rd_direct;
      end
    end
  end
endmodule // adccal_regs

// ### rtl/adccal_defs.vh
`ifndef ADCCAL_DEFS_VH
`define ADCCAL_DEFS_VH

// register selects on the byte port
`define ADCCAL_SEL_CTRL 3'h0
`define ADCCAL_SEL_DATA 3'h1
`define ADCCAL_SEL_OFFS 3'h2
`define ADCCAL_SEL_PFS 3'h3
`define ADCCAL_SEL_NFS 3'h4

// byte lanes of a three-byte register
`define ADCCAL_BYTE_LO 2'h0
`define ADCCAL_BYTE_MID 2'h1
`define ADCCAL_BYTE_HI 2'h2

// control register fields
`define ADCCAL_CTRL_MODE_HI 11
`define ADCCAL_CTRL_MODE_LO 9
`define ADCCAL_CTRL_BIPOLAR 8
`define ADCCAL_CTRL_GAIN_HI 7
`define ADCCAL_CTRL_GAIN_LO 5
`define ADCCAL_CTRL_STANDBY 3

// operating-mode codes
`define ADCCAL_MODE_CONVERT 3'h0
`define ADCCAL_MODE_SELF_CAL 3'h1
`define ADCCAL_MODE_SYS_OFFS 3'h2
`define ADCCAL_MODE_SYS_PFS 3'h3
`define ADCCAL_MODE_SYS_NFS 3'h4

// control reset: self-cal mode, bipolar, gain 1, filter code left to the user
`define ADCCAL_CTRL_RESET 24'h000300

// calibration run time
`define ADCCAL_CAL_TIME_NS 160
`define ADCCAL_CLK_PERIOD_NS 10
`define ADCCAL_CAL_CYCLES (`ADCCAL_CAL_TIME_NS / `ADCCAL_CLK_PERIOD_NS)

`endif

// ### rtl/adccal_coeff_mem.v
`timescale 1ns/1ps
`include "adccal_defs.vh"

module adccal_coeff_mem #(
  parameter WIDTH = 24
) (
  input wire clk,
  input wire sys_rst,
  input wire wr_en,
  input wire [1:0] wr_index,
  input wire [1:0] wr_byte,
  input wire [7:0] wr_data,
  input wire [2:0] load_mask,
  input wire [WIDTH-1:0] load_offs,
  input wire [WIDTH-1:0] load_pfs,
  input wire [WIDTH-1:0] load_nfs,
  input wire [1:0] rd_index,
  output reg [WIDTH-1:0] rd_word,
  output reg [WIDTH-1:0] offs_word
);
  reg [WIDTH-1:0] mem [0:2];
  integer i;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (i = 0; i < 3; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
      rd_word <= {WIDTH{1'b0}};
      offs_word <= {WIDTH{1'b0}};
    end else begin
      // a calibration result takes priority over a host byte write
      if (load_mask[0]) begin
        mem[0] <= load_offs;
      end else if (wr_en && wr_index == 2'h0) begin
        mem[0][wr_byte*8 +: 8] <= wr_data;
      end
      if (load_mask[1]) begin
        mem[1] <= load_pfs;
      end else if (wr_en && wr_index == 2'h1) begin
        mem[1][wr_byte*8 +: 8] <= wr_data;
      end
      if (load_mask[2]) begin
        mem[2] <= load_nfs;
      end else if (wr_en && wr_index == 2'h2) begin
        mem[2][wr_byte*8 +: 8] <= wr_data;
      end
      rd_word <= (rd_index == 2'h3) ? {WIDTH{1'b0}} : mem[rd_index];
      offs_word <= mem[0];
    end
  end
endmodule // adccal_coeff_mem

// ### sim/adccal_regs_asserts.sv
`timescale 1ns/1ps
module adccal_chk (
  input wire clk,
  input wire sys_rst,
  input wire wr_en,
  input wire rd_en,
  input wire [2:0] reg_sel,
  input wire [1:0] byte_sel,
  input wire [7:0] wr_data,
  input wire sample_valid,
  input wire rd_valid,
  input wire conversion_ready_n,
  input wire [2:0] gain_select,
  input wire calibrating
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire cw = wr_en && reg_sel == 3'h0;
  a_hi_ready: assert property (cw && byte_sel inside {2'h1, 2'h2} |=> conversion_ready_n)
    else $error("ready not cleared by control write");
  a_mode_cal: assert property (cw && byte_sel == 2'h1 && wr_data[3:1] inside {[3'h1:3'h4]}
    |=> calibrating) else $error("calibration not restarted");
  a_lo_nocal: assert property (cw && byte_sel == 2'h0 && !calibrating |=> !calibrating)
    else $error("low byte write started calibration");
  a_rd_lat: assert property (rd_en |-> ##2 rd_valid) else $error("read answer late");
  a_cal_ready: assert property (calibrating |-> conversion_ready_n)
    else $error("ready low while calibrating");
  a_ready_src: assert property ($fell(conversion_ready_n) |-> $past(sample_valid))
    else $error("ready low without sample");
  a_gain_copy: assert property (cw && byte_sel == 2'h0
    |-> ##2 gain_select == $past(wr_data[7:5], 2)) else $error("gain field wrong");
  a_cal_ends: assert property ($rose(calibrating) |-> ##[1:40] !calibrating)
    else $error("calibration never ends");
endmodule // adccal_chk
bind adccal_regs adccal_chk u_chk (.clk(clk), .sys_rst(sys_rst), .wr_en(wr_en), .rd_en(rd_en),
  .reg_sel(reg_sel), .byte_sel(byte_sel), .wr_data(wr_data), .sample_valid(sample_valid),
  .rd_valid(rd_valid), .conversion_ready_n(conversion_ready_n), .gain_select(gain_select),
  .calibrating(calibrating));

// ### sim/adccal_host.sv
`timescale 1ns/1ps
module adccal_host (
  input wire clk,
  input wire [7:0] rd_data,
  output logic wr_en = 1'b0,
  output logic rd_en = 1'b0,
  output logic [2:0] reg_sel = 3'h0,
  output logic [1:0] byte_sel = 2'h0,
  output logic [7:0] wr_data = 8'h00
);
  task automatic wr(input logic [2:0] s, input logic [1:0] b, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    reg_sel <= s;
    byte_sel <= b;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    // released data is scrambled so a stale byte cannot pass for a fresh one
    wr_data <= ~d;
    #1;
  endtask
  task automatic rd(input logic [2:0] s, input logic [1:0] b, output logic [7:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    reg_sel <= s;
    byte_sel <= b;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    #1 d = rd_data;
  endtask
  // whole-register writes, high byte first
  task automatic wr24(input logic [2:0] s, input logic [23:0] w);
    for (int i = 2; i >= 0; i--) wr(s, i[1:0], w[8*i +: 8]);
  endtask
endmodule // adccal_host

// ### sim/test_adc_control_write_and_calibration_regs.sv
`timescale 1ns/1ps
module test_adc_control_write_and_calibration_regs;
  localparam logic [23:0] OFFS = 24'h000123, PFS = 24'h4a5b6c, NFS = 24'h3c2d1e;
  logic clk = 1'b0, sys_rst = 1'b1, sample_valid = 1'b0;
  logic [23:0] sample_raw = 24'h0, offs_in = OFFS, pfs_in = PFS, nfs_in = NFS, w;
  logic [7:0] b;
  wire wr_en, rd_en, rd_valid, ready_n, calibrating, bipolar;
  wire [2:0] reg_sel, gain_select;
  wire [1:0] byte_sel;
  wire [7:0] wr_data, rd_data;
  wire [23:0] result;
  int n_errors = 0, samples_checked = 0, cyc = 0;
  always #5 clk = ~clk;
  adccal_host u_host (.clk(clk), .rd_data(rd_data), .wr_en(wr_en), .rd_en(rd_en),
    .reg_sel(reg_sel), .byte_sel(byte_sel), .wr_data(wr_data));
  adccal_regs #(.CAL_CYCLES(4)) u_dut (.clk(clk), .sys_rst(sys_rst), .wr_en(wr_en),
    .rd_en(rd_en), .reg_sel(reg_sel), .byte_sel(byte_sel), .wr_data(wr_data),
    .sample_valid(sample_valid), .sample_raw(sample_raw), .cal_offs_in(offs_in),
    .cal_pfs_in(pfs_in), .cal_nfs_in(nfs_in), .rd_data(rd_data), .rd_valid(rd_valid),
    .conversion_ready_n(ready_n), .result(result), .gain_select(gain_select), .bipolar(bipolar),
    .calibrating(calibrating));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd24(input logic [2:0] s);
    logic [7:0] d;
    for (int i = 0; i < 3; i++) begin
      u_host.rd(s, i[1:0], d);
      w[8*i +: 8] = d;
    end
  endtask
  task automatic samp(input logic [23:0] raw);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_raw <= raw;
    @(posedge clk);
    sample_valid <= 1'b0;
    #1;
  endtask
  task tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clk);
    rd24(3'h2); chk(w, OFFS);
    rd24(3'h3); chk(w, PFS);
    rd24(3'h4); chk(w, NFS);
    chk(bipolar, 1'b1);
    $display("test cal_load done");
    u_host.wr(3'h0, 2'h1, 8'h01); chk(ready_n, 1'b1);
    chk(calibrating, 1'b0);
    samp(OFFS); chk(ready_n, 1'b0);
    chk(result, 24'h0);
    u_host.wr(3'h0, 2'h0, 8'ha0); chk(calibrating, 1'b0);
    chk(ready_n, 1'b0);
    @(posedge clk);
    #1 chk(gain_select, 3'h5);
    $display("test convert done");
    for (int m = 1; m < 5; m++) begin
      u_host.wr(3'h0, 2'h1, {4'h0, m[2:0], 1'b1}); chk(calibrating, 1'b1);
      samp(24'h000777); chk(ready_n, 1'b1);
      repeat (8) @(posedge clk);
      samp(OFFS + 24'h10); chk(ready_n, 1'b0);
      chk(result, 24'h10);
    end
    rd24(3'h1);
    chk(w, 24'h000010);
    chk(ready_n, 1'b1);
    rd24(3'h0);
    chk(w, 24'h0009a0);
    u_host.wr(3'h0, 2'h0, 8'ha8);
    samp(OFFS);
    chk(ready_n, 1'b1);
    chk(calibrating, 1'b0);
    u_host.wr(3'h0, 2'h0, 8'ha0);
    samp(OFFS + 24'h20);
    chk(ready_n, 1'b0);
    chk(result, 24'h20);
    $display("test data done");
    @(posedge clk) nfs_in <= 24'h0a0b0c;
    u_host.wr(3'h0, 2'h2, 8'h00); chk(ready_n, 1'b1);
    $display("test recal done");
    u_host.wr24(3'h3, 24'h5a1e3c);
    rd24(3'h3); chk(w, 24'h5a1e3c);
    rd24(3'h4);
    chk(w, 24'h0a0b0c);
    u_host.rd(3'h6, 2'h0, b); chk(b, 8'h00);
    $display("test coeff done");
    u_host.wr(3'h0, 2'h1, 8'h0a);
    chk(calibrating, 1'b0);
    chk(ready_n, 1'b1);
    @(posedge clk);
    #1 chk(bipolar, 1'b0);
    u_host.wr24(3'h0, 24'h0003e0);
    chk(calibrating, 1'b1);
    chk(ready_n, 1'b1);
    repeat (8) @(posedge clk);
    samp(OFFS);
    chk(ready_n, 1'b0);
    chk(result, 24'h0);
    chk(gain_select, 3'h7);
    rd24(3'h3);
    chk(w, PFS);
    $display("test full write done");
    u_host.wr24(3'h2, 24'h111111);
    @(posedge clk) sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clk);
    rd24(3'h2);
    chk(w, OFFS);
    rd24(3'h0);
    chk(w, 24'h000300);
    chk(gain_select, 3'h0);
    chk(bipolar, 1'b1);
    $display("test reset done");
    tally_and_finish();
  end
endmodule // test_adc_control_write_and_calibration_regs
